// ===== include/boot_strap_defs.vh
// Constants for the boot-strap capture and boot-source ordering block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef BOOT_STRAP_DEFS_VH
`define BOOT_STRAP_DEFS_VH

// ----------------------------------------
// Boot source codes
// ----------------------------------------
`define SRC_NONE     3'h0
`define SRC_NAND     3'h1
`define SRC_SD       3'h2
`define SRC_USB      3'h3
`define SRC_NOR      3'h4
`define SRC_SPINAND  3'h5

// ----------------------------------------
// Strap bit positions in the captured pattern
// ----------------------------------------
`define STRAP_NAND_BIT 0
`define STRAP_USB_BIT  1
`define STRAP_NOR_BIT  2
`define STRAP_DEFAULT  3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS      5000
`define SETTLE_LAST        3'h3
`define USB_SHORT_WAIT_US  1000
`define USB_LONG_WAIT_US   100000
`define SLOT_LAST          2'h3

`endif

// ===== logic/boot_strap_source_select.v
// Boot-strap capture and boot-source sequencer.
// Assumes straps and card detect are asynchronous board pins; NRST from a reset supervisor.
`timescale 1ns/10ps
`include "boot_strap_defs.vh"
`default_nettype none

module boot_strap_source_select #(
  parameter USB_SHORT_CYCLES = (`USB_SHORT_WAIT_US * 1000000) / `CLK_PERIOD_PS,
  parameter USB_LONG_CYCLES  = (`USB_LONG_WAIT_US / 1000) * (1000000000 / `CLK_PERIOD_PS)
) (
  input  wire       CLK,
  input  wire       NRST,
  input  wire       NAND_PRIORITY_STRAP,
  input  wire       USB_PRIORITY_STRAP,
  input  wire       NOR_PRIORITY_STRAP,
  input  wire       CARD_PRESENCE_PIN,
  input  wire       ATTEMPT_OK,
  input  wire       ATTEMPT_FAIL,
  output reg  [2:0] BOOT_STRAP_CONFIG,
  output reg  [2:0] BOOT_SOURCE,
  output reg        ATTEMPT_START,
  output reg  [2:0] ATTEMPT_SOURCE,
  output reg        BOOT_DONE,
  output reg        BOOT_EXHAUSTED
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta;
  reg rst_sync;

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // Pin synchronisers: three stages, change counts when stages two and three agree
  // ----------------------------------------
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg [3:0] pin_s3;
  reg [3:0] pin_ok;
  wire [3:0] pin_raw = {CARD_PRESENCE_PIN, NOR_PRIORITY_STRAP, USB_PRIORITY_STRAP, NAND_PRIORITY_STRAP};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pin
      always @(posedge CLK or negedge rst_sync)
      begin
        if (!rst_sync)
        begin
          pin_s1[g] <= 1'b1;
          pin_s2[g] <= 1'b1;
          pin_s3[g] <= 1'b1;
          pin_ok[g] <= 1'b1;
        end
        else
        begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g])
            pin_ok[g] <= pin_s3[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Order table
  // ----------------------------------------
  // Pin filters need four edges after release before the level is trusted
  function [11:0] order_of;
    input [2:0] cfg;
    begin
      if (!cfg[`STRAP_USB_BIT])
      begin
        if (!cfg[`STRAP_NOR_BIT])
          order_of = {`SRC_USB, `SRC_NOR, `SRC_NAND, `SRC_SD};
        else
          order_of = {`SRC_USB, `SRC_NAND, `SRC_SD, `SRC_NONE};
      end
      else if (!cfg[`STRAP_NOR_BIT])
        order_of = {`SRC_NOR, `SRC_NAND, `SRC_SD, `SRC_USB};
      else if (!cfg[`STRAP_NAND_BIT])
        order_of = {`SRC_SPINAND, `SRC_NAND, `SRC_USB, `SRC_NONE};
      else
        order_of = {`SRC_NAND, `SRC_SD, `SRC_USB, `SRC_NONE};
    end
  endfunction

  function [2:0] slot_src;
    input [11:0] ord;
    input [1:0]  slot;
    begin
      case (slot)
        2'h0:    slot_src = ord[11:9];
        2'h1:    slot_src = ord[8:6];
        2'h2:    slot_src = ord[5:3];
        default: slot_src = ord[2:0];
      endcase
    end
  endfunction

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  localparam ST_SETTLE = 3'h0;
  localparam ST_LATCH  = 3'h1;
  localparam ST_ISSUE  = 3'h2;
  localparam ST_WAIT   = 3'h3;
  localparam ST_DONE   = 3'h4;
  localparam ST_FAIL   = 3'h5;

  reg [2:0]  state;
  reg [2:0]  settle;
  reg [1:0]  slot;
  reg [11:0] order;
  reg        sd_tried;
  reg        sd_forced;
  reg [31:0] wait_cnt;
  reg [2:0]  cur;

  wire [2:0] slot_now = slot_src(order, slot);
  // USB in the first order slot gets only the short wait, also after a forced SD try; otherwise the long one
  wire       short_usb = (cur == `SRC_USB) && (slot == 2'h0);

  always @(posedge CLK or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state             <= ST_SETTLE;
      settle            <= 3'h0;
      slot              <= 2'h0;
      order             <= 12'h000;
      sd_tried          <= 1'b0;
      sd_forced         <= 1'b0;
      wait_cnt          <= 32'h0;
      cur               <= `SRC_NONE;
      BOOT_STRAP_CONFIG <= `STRAP_DEFAULT;
      BOOT_SOURCE       <= `SRC_NONE;
      ATTEMPT_START     <= 1'b0;
      ATTEMPT_SOURCE    <= `SRC_NONE;
      BOOT_DONE         <= 1'b0;
      BOOT_EXHAUSTED    <= 1'b0;
    end
    else
    begin
      ATTEMPT_START <= 1'b0;
      case (state)
        ST_SETTLE:
        begin
          settle <= settle + 3'h1;
          if (settle == `SETTLE_LAST)
            state <= ST_LATCH;
        end
        ST_LATCH:
        begin
          // Only capture point after each reset release; later strap pin changes are ignored
          BOOT_STRAP_CONFIG <= pin_ok[2:0];
          order             <= order_of(pin_ok[2:0]);
          state             <= ST_ISSUE;
        end
        ST_ISSUE:
        begin
          if (!sd_tried && !pin_ok[3] && slot_now != `SRC_SD && !sd_forced)
          begin
            cur       <= `SRC_SD;
            sd_forced <= 1'b1;
            sd_tried  <= 1'b1;
            ATTEMPT_START  <= 1'b1;
            ATTEMPT_SOURCE <= `SRC_SD;
            wait_cnt  <= 32'h0;
            state     <= ST_WAIT;
          end
          else if (slot_now == `SRC_NONE || (slot_now == `SRC_SD && sd_tried))
          begin
            if (slot == `SLOT_LAST || slot_now == `SRC_NONE)
              state <= ST_FAIL;
            else
              slot <= slot + 2'h1;
          end
          else
          begin
            cur            <= slot_now;
            if (slot_now == `SRC_SD)
              sd_tried <= 1'b1;
            ATTEMPT_START  <= 1'b1;
            ATTEMPT_SOURCE <= slot_now;
            wait_cnt       <= 32'h0;
            state          <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          wait_cnt <= wait_cnt + 32'h1;
          if (ATTEMPT_OK)
          begin
            BOOT_SOURCE <= cur;
            BOOT_DONE   <= 1'b1;
            state       <= ST_DONE;
          end
          else if (ATTEMPT_FAIL
                   || (cur == `SRC_USB && short_usb && wait_cnt == USB_SHORT_CYCLES - 1)
                   || (cur == `SRC_USB && !short_usb && wait_cnt == USB_LONG_CYCLES - 1))
          begin
            if (sd_forced && cur == `SRC_SD && slot == 2'h0 && slot_now != `SRC_SD)
              state <= ST_ISSUE;
            else if (slot == `SLOT_LAST)
              state <= ST_FAIL;
            else
            begin
              slot  <= slot + 2'h1;
              state <= ST_ISSUE;
            end
          end
        end
        ST_FAIL:
        begin
          BOOT_EXHAUSTED <= 1'b1;
        end
        ST_DONE:
        begin
          BOOT_DONE <= 1'b1;
        end
        default:
        begin
          state <= ST_SETTLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== tb/board_model.sv
// Board side of the boot block: strap resistors and reset supervisor.
// Assumes one clock; HOLD stands in for the long power-up reset time.
`timescale 1ns/10ps
`default_nettype none
module board_model #(
  parameter int HOLD = 6
) (
  input  wire logic       clk,
  input  wire logic       restart,
  input  wire logic [2:0] pull_low,
  output logic            nrst,
  output logic      [2:0] straps
);
  logic [3:0] cnt = 4'(HOLD);
  // Internal pull-ups unless a resistor pulls low
  assign straps = ~pull_low;
  assign nrst   = (cnt == 4'h0);
  always @(posedge clk)
    if (restart)
      cnt <= 4'(HOLD);
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
endmodule
`default_nettype wire

// ===== tb/boot_strap_source_select_bench.sv
// Testbench: boots under every strap pattern and checks the attempt order.
// Assumes board_model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module boot_strap_source_select_bench;
  logic clk = 0, restart = 0, card = 1, ok = 0, fail = 0;
  logic [2:0] pull_low = 3'h0;
  wire logic nrst, start, done, exh;
  wire logic [2:0] straps, cfg, src, asrc;
  int failures = 0;
  int n_compared = 0;
  initial forever #2.5 clk = ~clk;
  board_model u_board_model (.clk(clk), .restart(restart), .pull_low(pull_low), .nrst(nrst), .straps(straps));
  boot_strap_source_select #(.USB_SHORT_CYCLES(8), .USB_LONG_CYCLES(16)) u_boot_strap_source_select (
    .CLK(clk), .NRST(nrst), .NAND_PRIORITY_STRAP(straps[0]), .USB_PRIORITY_STRAP(straps[1]),
    .NOR_PRIORITY_STRAP(straps[2]), .CARD_PRESENCE_PIN(card), .ATTEMPT_OK(ok), .ATTEMPT_FAIL(fail),
    .BOOT_STRAP_CONFIG(cfg), .BOOT_SOURCE(src), .ATTEMPT_START(start), .ATTEMPT_SOURCE(asrc),
    .BOOT_DONE(done), .BOOT_EXHAUSTED(exh));
  task finish_test;
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(string what, logic [2:0] exp, logic [2:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Attempt order per captured {nor,usb,nand}, three bits a source, zero ends
  function automatic logic [11:0] order(logic [2:0] c);
    if (!c[1])
      return c[2] ? 12'h650 : 12'h70a;
    if (!c[2])
      return 12'h853;
    return c[0] ? 12'h298 : 12'ha58;
  endfunction
  task boot(logic [2:0] cfg_want, logic c);
    @(posedge clk);
    pull_low <= ~cfg_want;
    card <= c;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask
  task run_seq(logic [11:0] seq, int pass_at);
    int i, k;
    for (k = 0; k < 4 && k <= pass_at && seq[11-3*k -: 3] != 3'h0; k++)
    begin
      for (i = 0; start !== 1'b1 && i < 60; i++) @(posedge clk);
      check("attempt start", 3'h1, {2'h0, start});
      check("attempt source", seq[11-3*k -: 3], asrc);
      if (k == pass_at)
        ok <= 1'b1;
      else
        fail <= 1'b1;
      @(posedge clk);
      ok <= 1'b0;
      fail <= 1'b0;
    end
  endtask
  // Unanswered USB attempt must end on its own after n cycles
  task usb_silent(int n);
    int i;
    for (i = 0; start !== 1'b1 && i < 60; i++) @(posedge clk);
    check("usb attempt", 3'h3, asrc);
    repeat (n) @(posedge clk);
    check("usb wait early end", 3'h0, {2'h0, start | exh});
    @(posedge clk);
    check("usb wait end", 3'h1, {2'h0, start | exh});
  endtask
  initial
  begin
    int p;
    for (p = 0; p < 8; p++)
    begin
      boot(3'(p), 1'b1);
      run_seq(order(3'(p)), 9);
      repeat (20) @(posedge clk);
      check("exhausted", 3'h1, {2'h0, exh});
      check("config", 3'(p), cfg);
    end
    boot(3'h6, 1'b0);
    run_seq(12'h54b, 9);
    boot(3'h5, 1'b1);
    usb_silent(8);
    check("source after usb", 3'h1, asrc);
    boot(3'h3, 1'b1);
    run_seq(12'h850, 9);
    usb_silent(16);
    check("exhausted after usb", 3'h1, {2'h0, exh});
    boot(3'h7, 1'b1);
    run_seq(12'h298, 1);
    pull_low <= 3'h7;
    repeat (12) @(posedge clk);
    check("done", 3'h1, {2'h0, done});
    check("boot source", 3'h2, src);
    check("config", 3'h7, cfg);
    finish_test();
  end
  // Run needs about 500 cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire

// ===== tb/boot_strap_source_select_sva.sv
// Port-level checks of the boot-strap capture and source ordering.
// Assumes straps stay put for at least eight cycles after reset release.
`timescale 1ns/10ps
`default_nettype none
module boot_strap_source_select_sva #(
  parameter USB_SHORT_CYCLES = 8,
  parameter USB_LONG_CYCLES  = 16
) (
  input wire       CLK,
  input wire       NRST,
  input wire       NAND_PRIORITY_STRAP,
  input wire       USB_PRIORITY_STRAP,
  input wire       NOR_PRIORITY_STRAP,
  input wire       CARD_PRESENCE_PIN,
  input wire       ATTEMPT_OK,
  input wire       ATTEMPT_FAIL,
  input wire [2:0] BOOT_STRAP_CONFIG,
  input wire [2:0] BOOT_SOURCE,
  input wire       ATTEMPT_START,
  input wire [2:0] ATTEMPT_SOURCE,
  input wire       BOOT_DONE,
  input wire       BOOT_EXHAUSTED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire [2:0] c = BOOT_STRAP_CONFIG;
  wire       s = ATTEMPT_START;
  property p_pulse; s |=> !s; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_capture; $rose(NRST) |-> ##8 c == {NOR_PRIORITY_STRAP, USB_PRIORITY_STRAP, NAND_PRIORITY_STRAP}; endproperty
  a_capture: assert property (p_capture) else $error("straps not captured");
  property p_hold; BOOT_DONE || BOOT_EXHAUSTED |-> $stable(c); endproperty
  a_hold: assert property (p_hold) else $error("config changed after capture");
  property p_dflt; s && c == 3'h7 |-> ATTEMPT_SOURCE inside {3'h1, 3'h2, 3'h3}; endproperty
  a_dflt: assert property (p_dflt) else $error("bad source for default");
  property p_usb; s && !c[1] |-> ATTEMPT_SOURCE != 3'h5; endproperty
  a_usb: assert property (p_usb) else $error("bad source with usb first");
  property p_nor; s && c[2:1] == 2'b01 |-> ATTEMPT_SOURCE inside {3'h1, 3'h2, 3'h3, 3'h4}; endproperty
  a_nor: assert property (p_nor) else $error("bad source with nor first");
  property p_spin; s && c == 3'h6 |-> ATTEMPT_SOURCE != 3'h4; endproperty
  a_spin: assert property (p_spin) else $error("bad source with spi nand first");
  property p_ok; s ##1 ATTEMPT_OK |=> BOOT_DONE && BOOT_SOURCE == $past(ATTEMPT_SOURCE); endproperty
  a_ok: assert property (p_ok) else $error("success not reported");
  // USB attempts may time out on their own, so left out here
  property p_fail; s && ATTEMPT_SOURCE != 3'h3 ##1 ATTEMPT_FAIL && !ATTEMPT_OK |-> ##[1:3] (s || BOOT_EXHAUSTED); endproperty
  a_fail: assert property (p_fail) else $error("no next attempt");
  c_done: cover property (BOOT_DONE);
  c_exh: cover property (BOOT_EXHAUSTED);
  c_spin: cover property (s && ATTEMPT_SOURCE == 3'h5);
endmodule
bind boot_strap_source_select boot_strap_source_select_sva #(.USB_SHORT_CYCLES(USB_SHORT_CYCLES),
  .USB_LONG_CYCLES(USB_LONG_CYCLES)) u_boot_strap_source_select_sva (.CLK(CLK), .NRST(NRST),
  .NAND_PRIORITY_STRAP(NAND_PRIORITY_STRAP), .USB_PRIORITY_STRAP(USB_PRIORITY_STRAP),
  .NOR_PRIORITY_STRAP(NOR_PRIORITY_STRAP), .CARD_PRESENCE_PIN(CARD_PRESENCE_PIN), .ATTEMPT_OK(ATTEMPT_OK),
  .ATTEMPT_FAIL(ATTEMPT_FAIL), .BOOT_STRAP_CONFIG(BOOT_STRAP_CONFIG), .BOOT_SOURCE(BOOT_SOURCE),
  .ATTEMPT_START(ATTEMPT_START), .ATTEMPT_SOURCE(ATTEMPT_SOURCE), .BOOT_DONE(BOOT_DONE),
  .BOOT_EXHAUSTED(BOOT_EXHAUSTED));
`default_nettype wire
